// ===== verilog/ists_pkg.sv
// Constants, register map, status codes and types of the I2C byte engine.
// Assumes a 200 MHz clk and an AXI4-Lite master on the register side.
// Contract
// - Enter slave transmit only after own address with read bit.
// - On own address plus read, set event flag and post a status code.
// - Arbitration lost, then addressed for read: slave transmit, status 0xB0.
// - Acknowledge assertion cleared: send last byte, then report 0xC0 or 0xC8.
// - After last byte become not addressed; data line stays released.
// - Acknowledge assertion clear: ignore own and general call addresses.
// - At 0x08 software loads target address; engine sends it, samples ack.
// - At 0x10 address with read bit switches to master receive mode.
// - Master transmit reports 0x18, 0x20, 0x28 and 0x30 distinctly.
// - In 0x18..0x30 with no requests, send next data byte, sample ack. The engine sends nothing while receive mode is still set.
// - In 0x18..0x30 start request alone gives a repeated START.
// - Stop request alone sends STOP; hardware clears stop request.
// - Start and stop requests: STOP then START; stop request cleared.
// - Arbitration lost reports 0x38; without start request, release bus.
// - In 0x38 with start request, START once the bus is free.
// - Acknowledge assertion clear keeps the engine isolated from the bus.
// - Hold the bus, clock low, while the event flag stays set. After 0x38, 0xC0 or 0xC8 the engine releases SCL with the flag set.
// - Own address in upper seven bits; bit 0 enables general call. The engine stores bit 0 but never recognises the general call.
package ists_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SCL_HALF_NS = 5000;
  // Least half period, rounded up to whole clock cycles
  localparam int unsigned SCL_HALF_CYC =
    (SCL_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 16;

  localparam int unsigned OFS_CTRL = 32'h00;
  localparam int unsigned OFS_STAT = 32'h04;
  localparam int unsigned OFS_DATA = 32'h08;
  localparam int unsigned OFS_ADDR = 32'h0c;
  localparam int unsigned OFS_MODE = 32'h10;

  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_DATA = 3'h2;
  localparam logic [2:0] IDX_ADDR = 3'h3;
  localparam logic [2:0] IDX_MODE = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;

  localparam int CTL_EN = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_EVT = 3;
  localparam int CTL_AA = 2;
  localparam int MODE_MRX = 0;
  localparam int MODE_BUSY = 1;

  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_AW_ACK = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_D_ACK = 8'h28;
  localparam logic [7:0] SC_D_NACK = 8'h30;
  localparam logic [7:0] SC_ARB = 8'h38;
  localparam logic [7:0] SC_AR_ACK = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_SR_ACK = 8'ha8;
  localparam logic [7:0] SC_ARB_SR = 8'hb0;
  localparam logic [7:0] SC_SD_ACK = 8'hb8;
  localparam logic [7:0] SC_SD_NACK = 8'hc0;
  localparam logic [7:0] SC_SLAST = 8'hc8;
  localparam logic [7:0] SC_IDLE = 8'hf8;

  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_EDGE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_MSTART = 4'h1,
    ST_MBIT = 4'h2,
    ST_MHOLD = 4'h3,
    ST_MSTOP = 4'h4,
    ST_SADDR = 4'h5,
    ST_SACK = 4'h6,
    ST_SHOLD = 4'h7,
    ST_STX = 4'h8
  } ists_state_t;

  typedef struct packed {
    logic interface_enable;
    logic start_request;
    logic stop_request;
    logic event_flag;
    logic assert_ack;
  } ists_ctrl_t;
endpackage

// ===== verilog/ists_top.sv
// I2C byte engine: master transmitter and slave transmitter with status.
// Assumes SCL/SDA open-drain wires resolved outside; AXI4-Lite registers.
`timescale 1ns/1ps
module ists_top
  import ists_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned HALF_CYCLES = SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_pin,
  output logic scl_val,
  output logic scl_oe,
  input wire logic sda_pin,
  output logic sda_val,
  output logic sda_oe
);
  localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(HALF_CYCLES - 1);

  if (HALF_CYCLES < 4 || HALF_CYCLES >= (1 << CNT_W) || ADDR_W < 5) begin
    $error("ists_top: unsupported HALF_CYCLES or ADDR_W");
  end

  function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(OFS_CTRL)) return IDX_CTRL;
    if (a == ADDR_W'(OFS_STAT)) return IDX_STAT;
    if (a == ADDR_W'(OFS_DATA)) return IDX_DATA;
    if (a == ADDR_W'(OFS_ADDR)) return IDX_ADDR;
    if (a == ADDR_W'(OFS_MODE)) return IDX_MODE;
    return IDX_NONE;
  endfunction

  ists_state_t state_q, state_d;
  ists_ctrl_t control_reg_q;
  logic [7:0] status_code_reg_q, stat_d;
  logic [7:0] data_shift_reg_q, own_address_reg_q;
  logic master_receive_mode_q, mrx_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] tx_q, tx_d;
  logic [CNT_W-1:0] cnt_q;
  logic rd_q, rd_d, addr_q, addr_d, last_q, last_d;
  logic arb_q, arb_d, rep_q, rep_d, ack_q, ack_d;
  logic evt_set, sto_clr, scl_low_d, sda_low_d;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic busy_q;
  logic [7:0] mon_q;
  logic [3:0] mcnt_q;
  logic [31:0] rd_word;

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  wire timed = state_q == ST_MSTART || state_q == ST_MBIT ||
               state_q == ST_MSTOP;
  wire rel_ph = (state_q == ST_MBIT) ? (ph_q == PH_HIGH) : (ph_q != PH_LOW);
  // Counting only once SCL is really high honours clock stretching
  wire stall = timed && rel_ph && !scl_s_q;
  wire tick = timed && !stall && cnt_q == HALF_M1;
  wire moved = state_d != state_q || ph_d != ph_q;

  wire aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
               !s_axi_bvalid;
  wire ar_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [2:0] widx = reg_idx(s_axi_awaddr);
  wire [2:0] ridx = reg_idx(s_axi_araddr);
  wire wr_en = s_axi_awready && s_axi_wstrb[0];
  wire wr_ctrl = wr_en && widx == IDX_CTRL;
  wire own_match = mon_q[7:1] == own_address_reg_q[7:1];
  wire en = control_reg_q.interface_enable;

  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rd_d = rd_q;
    addr_d = addr_q;
    last_d = last_q;
    arb_d = arb_q;
    rep_d = rep_q;
    ack_d = ack_q;
    mrx_d = master_receive_mode_q;
    stat_d = status_code_reg_q;
    evt_set = 1'b0;
    sto_clr = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        arb_d = 1'b0;
        if (control_reg_q.start_request && !control_reg_q.event_flag &&
            !busy_q && !start_det) begin
          state_d = ST_MSTART;
          ph_d = PH_EDGE;
          rep_d = 1'b0;
        end else if (start_det) begin
          state_d = ST_SADDR;
        end
      end
      ST_MSTART: begin
        if (tick && ph_q == PH_EDGE) begin
          state_d = ST_MHOLD;
          evt_set = 1'b1;
          stat_d = rep_q ? SC_RSTART : SC_START;
        end else if (tick) begin
          ph_d = ph_q + 2'h1;
        end
      end
      ST_MHOLD: begin
        // Decision ignores assert_ack
        if (!control_reg_q.event_flag) begin
          ph_d = PH_LOW;
          bit_d = '0;
          if (status_code_reg_q == SC_START ||
              status_code_reg_q == SC_RSTART) begin
            tx_d = data_shift_reg_q;
            rd_d = data_shift_reg_q[0];
            addr_d = 1'b1;
            state_d = ST_MBIT;
          end else if (control_reg_q.stop_request) begin
            state_d = ST_MSTOP;
          end else if (control_reg_q.start_request) begin
            state_d = ST_MSTART;
            rep_d = 1'b1;
          end else if (!master_receive_mode_q) begin
            tx_d = data_shift_reg_q;
            addr_d = 1'b0;
            state_d = ST_MBIT;
          end
        end
      end
      ST_MBIT: begin
        if (tick && ph_q == PH_LOW) begin
          ph_d = PH_HIGH;
        end else if (tick && bit_q != BIT_ACK) begin
          if (tx_q[7] && !sda_s_q) begin
            if (addr_q) begin
              arb_d = 1'b1;
              state_d = ST_SADDR;
            end else begin
              state_d = ST_IDLE;
              stat_d = SC_ARB;
              evt_set = 1'b1;
            end
          end else begin
            tx_d = {tx_q[6:0], 1'b1};
            bit_d = bit_q + 4'h1;
            ph_d = PH_LOW;
          end
        end else if (tick) begin
          state_d = ST_MHOLD;
          evt_set = 1'b1;
          if (addr_q && rd_q) begin
            mrx_d = 1'b1;
            stat_d = sda_s_q ? SC_AR_NACK : SC_AR_ACK;
          end else if (addr_q) begin
            stat_d = sda_s_q ? SC_AW_NACK : SC_AW_ACK;
          end else begin
            stat_d = sda_s_q ? SC_D_NACK : SC_D_ACK;
          end
        end
      end
      ST_MSTOP: begin
        if (tick && ph_q == PH_EDGE) begin
          // A pending start then waits in idle for the free bus
          state_d = ST_IDLE;
          sto_clr = 1'b1;
          mrx_d = 1'b0;
          stat_d = SC_IDLE;
        end else if (tick) begin
          ph_d = ph_q + 2'h1;
        end
      end
      ST_SADDR: begin
        if (stop_det) begin
          state_d = ST_IDLE;
        end else if (mcnt_q == BIT_ACK && scl_fall) begin
          if (own_match && mon_q[0] && control_reg_q.assert_ack) begin
            state_d = ST_SACK;
            stat_d = arb_q ? SC_ARB_SR : SC_SR_ACK;
          end else begin
            state_d = ST_IDLE;
            if (arb_q) begin
              stat_d = SC_ARB;
              evt_set = 1'b1;
            end
          end
        end
      end
      ST_SACK: begin
        if (scl_fall) begin
          state_d = ST_SHOLD;
          ph_d = PH_LOW;
          evt_set = 1'b1;
        end
      end
      ST_SHOLD: begin
        // One cycle of data setup before SCL is let go
        if (ph_q == PH_HIGH) begin
          state_d = ST_STX;
        end else if (!control_reg_q.event_flag) begin
          tx_d = data_shift_reg_q;
          last_d = !control_reg_q.assert_ack;
          bit_d = '0;
          ph_d = PH_HIGH;
        end
      end
      ST_STX: begin
        if (stop_det || start_det) begin
          state_d = ST_IDLE;
        end else if (scl_rise && bit_q == BIT_ACK) begin
          ack_d = !sda_s_q;
        end else if (scl_fall && bit_q != BIT_ACK) begin
          tx_d = {tx_q[6:0], 1'b1};
          bit_d = bit_q + 4'h1;
        end else if (scl_fall) begin
          evt_set = 1'b1;
          bit_d = BIT_DONE;
          if (!ack_q) begin
            stat_d = SC_SD_NACK;
            state_d = ST_IDLE;
          end else if (last_q) begin
            stat_d = SC_SLAST;
            state_d = ST_IDLE;
          end else begin
            stat_d = SC_SD_ACK;
            state_d = ST_SHOLD;
            ph_d = PH_LOW;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!en) begin
      state_d = ST_IDLE;
    end
  end

  always_comb begin
    unique case (state_q)
      ST_MSTART: sda_low_d = ph_q == PH_EDGE;
      // Keep SDA steady just after SCL falls to avoid a false edge
      ST_MBIT: sda_low_d = (ph_q == PH_LOW && cnt_q == '0) ? sda_oe :
                           !tx_q[7];
      ST_MHOLD: sda_low_d = sda_oe;
      ST_MSTOP: sda_low_d = ph_q != PH_EDGE;
      ST_SACK: sda_low_d = 1'b1;
      ST_SHOLD: sda_low_d = ph_q == PH_HIGH && !tx_q[7];
      ST_STX: sda_low_d = !tx_q[7];
      default: sda_low_d = 1'b0;
    endcase
  end

  assign scl_low_d = state_q == ST_MHOLD || state_q == ST_SHOLD ||
                     (timed && ph_q == PH_LOW);

  always_comb begin
    rd_word = '0;
    unique case (ridx)
      IDX_CTRL: begin
        rd_word[CTL_EN] = control_reg_q.interface_enable;
        rd_word[CTL_STA] = control_reg_q.start_request;
        rd_word[CTL_STO] = control_reg_q.stop_request;
        rd_word[CTL_EVT] = control_reg_q.event_flag;
        rd_word[CTL_AA] = control_reg_q.assert_ack;
      end
      IDX_STAT: rd_word[7:0] = status_code_reg_q;
      IDX_DATA: rd_word[7:0] = data_shift_reg_q;
      IDX_ADDR: rd_word[7:0] = own_address_reg_q;
      IDX_MODE: begin
        rd_word[MODE_MRX] = master_receive_mode_q;
        rd_word[MODE_BUSY] = busy_q;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else if (ce) begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_pin, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_pin, sda_m_q, sda_s_q};
    end
  end

  // Bus monitor keeps running while isolated, so recognition resumes at once
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      mon_q <= '0;
      mcnt_q <= BIT_DONE;
    end else if (ce) begin
      if (start_det) busy_q <= 1'b1;
      else if (stop_det) busy_q <= 1'b0;
      if (start_det) begin
        mcnt_q <= '0;
      end else if (scl_rise && mcnt_q != BIT_DONE) begin
        mon_q <= {mon_q[6:0], sda_s_q};
        mcnt_q <= mcnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ph_q <= PH_LOW;
      cnt_q <= '0;
      {bit_q, tx_q} <= '0;
      {rd_q, addr_q, last_q, arb_q, rep_q, ack_q} <= '0;
      master_receive_mode_q <= 1'b0;
      status_code_reg_q <= SC_IDLE;
      {scl_oe, sda_oe, scl_val, sda_val} <= '0;
    end else if (ce) begin
      state_q <= state_d;
      ph_q <= ph_d;
      cnt_q <= (moved || tick || stall || !timed) ? '0 : cnt_q + 1'b1;
      {bit_q, tx_q} <= {bit_d, tx_d};
      {rd_q, addr_q, last_q} <= {rd_d, addr_d, last_d};
      {arb_q, rep_q, ack_q} <= {arb_d, rep_d, ack_d};
      master_receive_mode_q <= mrx_d;
      status_code_reg_q <= stat_d;
      scl_oe <= scl_low_d && en;
      sda_oe <= sda_low_d && en;
      {scl_val, sda_val} <= 2'h0;
    end
  end

  // Hardware setting the event flag beats a software clear in one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      control_reg_q <= '0;
      data_shift_reg_q <= '0;
      own_address_reg_q <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        control_reg_q.interface_enable <= s_axi_wdata[CTL_EN];
        control_reg_q.start_request <= s_axi_wdata[CTL_STA];
        control_reg_q.stop_request <= s_axi_wdata[CTL_STO];
        control_reg_q.assert_ack <= s_axi_wdata[CTL_AA];
      end else if (sto_clr) begin
        control_reg_q.stop_request <= 1'b0;
      end
      control_reg_q.event_flag <= evt_set || (control_reg_q.event_flag &&
                                  !(wr_ctrl && !s_axi_wdata[CTL_EVT]));
      if (wr_en && widx == IDX_DATA) data_shift_reg_q <= s_axi_wdata[7:0];
      if (wr_en && widx == IDX_ADDR) own_address_reg_q <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {s_axi_awready, s_axi_wready, s_axi_bvalid} <= '0;
      {s_axi_arready, s_axi_rvalid} <= '0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else if (ce) begin
      s_axi_awready <= aw_go;
      s_axi_wready <= aw_go;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ar_go;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (ridx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ists_top

// ===== tb/ists_top_monitor.sv
// Port checker for the I2C byte engine: bus timing and pin drive.
// Assumes ce is held high; bound into every ists_top instance.
`timescale 1ns/1ps
module ists_top_monitor
  import ists_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_val,
  input wire logic scl_oe,
  input wire logic sda_val
);
  // A low stretch is a hold or a low half, never shorter than a half
  localparam int LOW_MIN = HALF_CYCLES - 1;
  logic [15:0] low_q;
  always_ff @(posedge clk) begin
    if (rst || !scl_oe) begin
      low_q <= 16'h0;
    end else if (low_q != 16'hffff) begin
      low_q <= low_q + 16'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_write_take: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=> s_axi_awready ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready apart");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready longer than one cycle");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_take: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered in two cycles");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  a_open_drain: assert property (!scl_val && !sda_val)
    else $error("pin driven high");
  a_low_half: assert property ($fell(scl_oe) |-> low_q >= LOW_MIN)
    else $error("clock low phase too short");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_scl: cover property ($fell(scl_oe));
endmodule // ists_top_monitor
bind ists_top ists_top_monitor #(.HALF_CYCLES(HALF_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .scl_val(scl_val), .scl_oe(scl_oe), .sda_val(sda_val)
);

// ===== tb/ists_peer.sv
// Far-side I2C party: a slave receiver, or a master that reads bytes.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ps
module ists_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic mst = 1'b0;
  logic sl_ack = 1'b1;
  logic aok = 1'b0;
  logic jam = 1'b0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] rx = 8'h0;
  logic [7:0] got [4];
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Listener stays quiet while this side masters the bus
  always @(negedge sda) if (scl && !mst) bitn = 4'hf;
  always @(posedge scl) if (!mst && bitn < 4'h8) rx = {rx[6:0], sda};
  always @(negedge scl) begin
    if (!mst) begin
      bitn = bitn + 4'h1;
      sda_oe = (bitn == 4'h8) && sl_ack || (bitn == 4'h9) && jam;
      if (bitn == 4'h9) bitn = 4'h0;
    end
  end
  // High half starts only once SCL reads high, so stretching is honoured
  task automatic bit9(input logic o, output logic i);
    sda_oe = !o;
    #62.5 scl_oe = 1'b0;
    wait (scl);
    #62.5 i = sda;
    scl_oe = 1'b1;
  endtask
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) bit9(o[k], i[k]);
  endtask
  task automatic rd(input logic [6:0] a, input logic rw, input int n,
                    input logic nk);
    logic [8:0] i;
    mst = 1'b1;
    sda_oe = 1'b1;
    #62.5 scl_oe = 1'b1;
    xfer({a, rw, 1'b1}, i);
    aok = !i[0];
    for (int b = 0; b < n && aok; b++) begin
      xfer({8'hff, nk && b == n - 1}, i);
      got[b] = i[8:1];
    end
    sda_oe = 1'b1;
    #62.5 scl_oe = 1'b0;
    wait (scl);
    #62.5 sda_oe = 1'b0;
    #62.5 mst = 1'b0;
  endtask
endmodule // ists_peer

// ===== tb/ists_top_tb.sv
// Bench for the I2C byte engine: AXI4-Lite software plus a bus peer.
// Assumes the peer model and the bound port checker are compiled.
`timescale 1ns/1ps
module ists_top_tb
  import ists_pkg::*;
  ;
  logic clk, rst, ce, awv, wv, bre, arv, rre;
  logic awr, wr, bv, arr, rv, scl_v, sda_v, scl_o, sda_o, pscl, psda;
  logic [7:0] awa, ara, aa, d0, d1;
  logic [6:0] oa, tgt;
  logic [31:0] wd, rdat, v;
  logic [3:0] ws;
  logic [1:0] br, rr;
  wire logic scl = !(scl_o | pscl);
  wire logic sda = !(sda_o | psda);
  int bad_count, compares, seed;
  ists_top #(.ADDR_W(8), .HALF_CYCLES(8)) uut (
    .clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .scl_pin(scl), .scl_val(scl_v), .scl_oe(scl_o),
    .sda_pin(sda), .sda_val(sda_v), .sda_oe(sda_o)
  );
  ists_peer peer (.scl(scl), .sda(sda), .scl_oe(pscl), .sda_oe(psda));
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    awa <= a[7:0];
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk({29'h0, bv, br}, {29'h0, 1'b1, er}, "write response");
    @(posedge clk);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
                     input logic [1:0] er);
    ara <= a[7:0];
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    rre <= 1'b0;
    chk({29'h0, rv, rr}, {29'h0, 1'b1, er}, "read response");
    @(posedge clk);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    axr(a, d, RESP_OKAY);
    chk(d, e, "register value");
  endtask
  task automatic poll(input logic [31:0] a, input int b, input logic lv);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      axr(a, d, RESP_OKAY);
      n++;
    end while (d[b] !== lv && n < 3000);
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] st);
    axw(OFS_CTRL, {24'h0, c}, RESP_OKAY);
    poll(OFS_CTRL, CTL_EVT, 1'b1);
    rdc(OFS_STAT, {24'h0, st});
  endtask
  task automatic snd(input logic [7:0] b, input logic [7:0] st);
    axw(OFS_DATA, {24'h0, b}, RESP_OKAY);
    go(8'h40 | aa, st);
    chk({24'h0, peer.rx}, {24'h0, b}, "byte on wire");
  endtask
  task automatic srv(input logic [7:0] st, input logic [7:0] b,
                     input logic [7:0] c);
    poll(OFS_CTRL, CTL_EVT, 1'b1);
    rdc(OFS_STAT, {24'h0, st});
    axw(OFS_DATA, {24'h0, b}, RESP_OKAY);
    axw(OFS_CTRL, {24'h0, c}, RESP_OKAY);
  endtask
  task automatic tend(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    chk(32'h0, 32'h1, "watchdog");
    final_report();
  end
  initial begin
    {awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    ce = 1'b1;
    ws = 4'hf;
    rst = 1'b1;
    seed = 43;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_STAT, 32'hf8);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_MODE, 32'h0);
    axw(OFS_STAT, 32'h55, RESP_OKAY);
    rdc(OFS_STAT, 32'hf8);
    axw(32'h20, 32'h1, RESP_SLVERR);
    axr(32'h20, v, RESP_SLVERR);
    oa = 7'($random(seed)) | 7'h08;
    axw(OFS_ADDR, {24'h0, oa, 1'b1}, RESP_OKAY);
    rdc(OFS_ADDR, {24'h0, oa, 1'b1});
    tend("registers");
    for (int p = 0; p < 2; p++) begin
      aa = p ? 8'h04 : 8'h00;
      tgt = 7'($random(seed));
      peer.sl_ack = 1'b1;
      go(8'h60 | aa, SC_START);
      snd({tgt, 1'b0}, SC_AW_ACK);
      repeat (40) @(posedge clk);
      chk({31'h0, scl}, 32'h0, "clock held");
      snd(8'($random(seed)), SC_D_ACK);
      peer.sl_ack = 1'b0;
      snd(8'($random(seed)), SC_D_NACK);
      go(8'h60 | aa, SC_RSTART);
      snd({tgt, 1'b0}, SC_AW_NACK);
      axw(OFS_CTRL, {24'h0, 8'h50 | aa}, RESP_OKAY);
      poll(OFS_MODE, MODE_BUSY, 1'b0);
      rdc(OFS_CTRL, {24'h0, 8'h40 | aa});
      rdc(OFS_STAT, 32'hf8);
      peer.sl_ack = 1'b1;
      go(8'h60 | aa, SC_START);
      snd({tgt, 1'b0}, SC_AW_ACK);
      go(8'h70 | aa, SC_START);
      rdc(OFS_CTRL, {24'h0, 8'h68 | aa});
      snd({tgt, 1'b0}, SC_AW_ACK);
      go(8'h60 | aa, SC_RSTART);
      snd({tgt, 1'b1}, SC_AR_ACK);
      rdc(OFS_MODE, 32'h3);
      axw(OFS_CTRL, {24'h0, 8'h50 | aa}, RESP_OKAY);
      poll(OFS_MODE, MODE_BUSY, 1'b0);
      tend("master");
    end
    go(8'h60, SC_START);
    peer.jam = 1'b1;
    snd({tgt, 1'b0}, SC_AW_ACK);
    axw(OFS_DATA, 32'h80, RESP_OKAY);
    go(8'h40, SC_ARB);
    chk({30'h0, scl_o, sda_o}, 32'h0, "bus released");
    axw(OFS_CTRL, 32'h60, RESP_OKAY);
    repeat (20) @(posedge clk);
    rdc(OFS_CTRL, 32'h60);
    {peer.jam, peer.sda_oe} = 2'h0;
    poll(OFS_CTRL, CTL_EVT, 1'b1);
    rdc(OFS_STAT, {24'h0, SC_START});
    snd({tgt, 1'b0}, SC_AW_ACK);
    axw(OFS_CTRL, 32'h50, RESP_OKAY);
    poll(OFS_MODE, MODE_BUSY, 1'b0);
    tend("arbitration");
    axw(OFS_CTRL, 32'h40, RESP_OKAY);
    peer.rd(oa, 1'b1, 1, 1'b0);
    chk({31'h0, peer.aok}, 32'h0, "address while isolated");
    peer.rd(7'h00, 1'b0, 0, 1'b0);
    chk({31'h0, peer.aok}, 32'h0, "general call isolated");
    rdc(OFS_STAT, 32'hf8);
    axw(OFS_CTRL, 32'h44, RESP_OKAY);
    peer.rd(oa, 1'b0, 0, 1'b0);
    chk({31'h0, peer.aok}, 32'h0, "write direction");
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    fork
      peer.rd(oa, 1'b1, 3, 1'b1);
      begin
        srv(SC_SR_ACK, d0, 8'h44);
        srv(SC_SD_ACK, d1, 8'h40);
        srv(SC_SLAST, 8'h0, 8'h44);
      end
    join
    chk({31'h0, peer.aok}, 32'h1, "own address read");
    chk({24'h0, peer.got[0]}, {24'h0, d0}, "slave byte");
    chk({24'h0, peer.got[1]}, {24'h0, d1}, "last byte");
    chk({24'h0, peer.got[2]}, 32'hff, "after last");
    fork
      peer.rd(oa, 1'b1, 1, 1'b1);
      begin
        srv(SC_SR_ACK, d1, 8'h44);
        srv(SC_SD_NACK, 8'h0, 8'h44);
      end
    join
    chk({24'h0, peer.got[0]}, {24'h0, d1}, "nacked byte");
    tend("slave");
    final_report();
  end
endmodule // ists_top_tb
